//--- core/sec_params.svh
`ifndef SEC_PARAMS_SVH
`define SEC_PARAMS_SVH

// Register offsets
`define SEC_OFF_ACS_HDR  12'h220
`define SEC_OFF_ACS      12'h224
`define SEC_OFF_EGR      12'h228
`define SEC_OFF_LTR_HDR  12'h230
`define SEC_OFF_LAT      12'h234
`define SEC_OFF_SS_HDR   12'h240
`define SEC_OFF_SS_CAP   12'h244
`define SEC_OFF_SS_CTL1  12'h248
`define SEC_OFF_SS_CTL2  12'h24c
`define SEC_OFF_LTSSM    12'h33c
`define SEC_OFF_HOT      12'h340
`define SEC_OFF_SMB      12'h344
`define SEC_OFF_FC_EN    12'h350
`define SEC_OFF_FC_THR1  12'h354
`define SEC_OFF_FC_THR2  12'h358
`define SEC_OFF_PWR      12'h360
`define SEC_OFF_LED      12'h364

// Capability header contents
`define SEC_ID_ACS       16'h000d
`define SEC_ID_LTR       16'h0018
`define SEC_ID_SS        16'h001e
`define SEC_CAP_VER      4'h1
`define SEC_NEXT_SS      12'h240
`define SEC_NEXT_END     12'h000

// Field positions
`define SEC_BIT_PEC_FAIL 29
`define SEC_BIT_UNSUP    30

// Reset values
`define SEC_ACS_CAP_BITS 7'h7f
`define SEC_EGR_SIZE     8'h08
`define SEC_SS_CAP_RST   3'b101
`define SEC_SMB_SEL_RST  1'b1
`define SEC_SMB_ADDR_HI  4'hd
`define SEC_PEC_DIS_RST  1'b1
`define SEC_THR_X1_RST   16'h0080
`define SEC_THR_X2_RST   16'h0200
`define SEC_THR_X4_RST   16'h0800
`define SEC_MAC_RST      16'h0004

// Edges from reset release until synchronised straps are valid
`define SEC_STRAP_WAIT   2'h2

`endif

//--- core/sec_pkg.sv
package sec_pkg;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [11:0] addr;
      logic [3:0]  be;
      logic [31:0] data;
   } sec_req_t;

   typedef struct packed {
      logic [6:0]  acsEn;
      logic [7:0]  egressVec;
      logic [12:0] snoopLat;
      logic [12:0] noSnoopLat;
      logic        pmL11En;
      logic        aspmL11En;
      logic        smbusSel;
      logic [6:0]  smbusAddr;
      logic        pecDisable;
      logic        pecFail;
      logic        unsupCmd;
      logic [1:0]  cplFcEn;
      logic [15:0] thrX1;
      logic [15:0] thrX2;
      logic [15:0] thrX4;
      logic        powerSaveOff;
      logic [6:0]  ledCtl;
   } sec_ctrl_t;

endpackage : sec_pkg

//--- core/sec_sync.sv
`timescale 1ns/1ps
module sec_sync #(
   parameter int W = 1
) (
   input  wire logic         clock,
   input  wire logic         sys_rst,
   input  wire logic [W-1:0] asyncIn,
   output logic      [W-1:0] syncOut
);
   logic [W-1:0] meta_q;

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         meta_q  <= '0;
         syncOut <= '0;
      end else begin
         meta_q  <= asyncIn;
         syncOut <= meta_q;
      end
   end
endmodule : sec_sync

//--- core/sec_cfg_regs.sv
`timescale 1ns/1ps
`include "sec_params.svh"

// Function
// R1 - Seven capability bits read one, read-only
// R2 - Egress vector size reads eight, read-only
// R3 - Seven access enables, writable, reset zero
// R4 - Eight-bit egress vector blocks peer requests
// R5 - Latency header id, version, next 240h
// R6 - Snoop latency value and scale, writable
// R7 - No-snoop latency value and scale, writable
// R8 - Substates header ends the capability chain
// R9 - Substates capability flags reset one-zero-one
// R10 - Loadable fields: config read-only, sideband loads
// R11 - L1.1 enables writable, reset zero
// R12 - Sideband select resets to SMBus
// R13 - Slave address high 1101b, low from straps
// R14 - Error code check disable resets one
// R15 - Check failure flag, sticky, write-one-clear
// R16 - Unsupported command flag, sticky, write-one-clear
// R17 - Completion flow enables per downstream port
// R18 - Three flow thresholds with documented resets
// R19 - Power saving disable writable and loadable
// R20 - Downstream access header id, version, next
// R21 - Reserved bits read zero, writes ignored
module sec_cfg_regs
   import sec_pkg::*;
(
   input  wire logic       clock,
   input  wire logic       sys_rst,
   input  wire logic       portIsUpPin,
   input  wire logic [2:0] gpioStrapPin,
   input  wire sec_req_t   cfgReq,
   input  wire sec_req_t   sbLoad,
   input  wire logic       pecFailEv,
   input  wire logic       unsupCmdEv,
   output logic [31:0]     cfgRdData,
   output logic            cfgRdValid,
   output sec_ctrl_t       ctrl
);
   logic        isUp;
   logic [2:0]  strap;
   logic [1:0]  strapCnt_q;
   logic        strapDone_q;
   logic [6:0]  acsEn_q;
   logic [7:0]  egress_q;
   logic [12:0] snoop_q;
   logic [12:0] noSnoop_q;
   logic [1:0]  l1En_q;
   logic        smbSel_q;
   logic [6:0]  smbAddr_q;
   logic        pecDis_q;
   logic        pecFail_q;
   logic        unsup_q;
   logic [1:0]  fcEn_q;
   logic [15:0] thrX1_q;
   logic [15:0] thrX2_q;
   logic [15:0] thrX4_q;
   logic        pwrOff_q;
   logic [6:0]  led_q;
   logic [2:0]  ssCap_q;
   logic [7:0]  ltssm_q;
   logic [15:0] hot_q;
   logic [15:0] mac_q;

   // Port role and strap pins arrive from outside the clock domain
   sec_sync #(.W(4)) u_sync (
      .clock   (clock),
      .sys_rst (sys_rst),
      .asyncIn ({portIsUpPin, gpioStrapPin}),
      .syncOut ({isUp, strap})
   );

   wire [11:0] cfgWord = {cfgReq.addr[11:2], 2'b00};
   wire [11:0] sbWord  = {sbLoad.addr[11:2], 2'b00};
   wire [31:0] cfgMask = {{8{cfgReq.be[3]}}, {8{cfgReq.be[2]}},
                          {8{cfgReq.be[1]}}, {8{cfgReq.be[0]}}};
   wire [31:0] sbMask  = {{8{sbLoad.be[3]}}, {8{sbLoad.be[2]}},
                          {8{sbLoad.be[1]}}, {8{sbLoad.be[0]}}};

   // Address decode; port-specific registers vanish on the other role
   wire hAcsH  = (cfgWord == `SEC_OFF_ACS_HDR) & ~isUp;
   wire hAcs   = (cfgWord == `SEC_OFF_ACS) & ~isUp;
   wire hEgr   = (cfgWord == `SEC_OFF_EGR) & ~isUp;
   wire hLtrH  = (cfgWord == `SEC_OFF_LTR_HDR) & isUp;
   wire hLat   = (cfgWord == `SEC_OFF_LAT) & isUp;
   wire hSsH   = (cfgWord == `SEC_OFF_SS_HDR);
   wire hSsC   = (cfgWord == `SEC_OFF_SS_CAP);
   wire hSs1   = (cfgWord == `SEC_OFF_SS_CTL1);
   wire hLtssm = (cfgWord == `SEC_OFF_LTSSM);
   wire hHot   = (cfgWord == `SEC_OFF_HOT);
   wire hSmb   = (cfgWord == `SEC_OFF_SMB) & isUp;
   wire hFc    = (cfgWord == `SEC_OFF_FC_EN) & isUp;
   wire hThr1  = (cfgWord == `SEC_OFF_FC_THR1) & isUp;
   wire hThr2  = (cfgWord == `SEC_OFF_FC_THR2) & isUp;
   wire hPwr   = (cfgWord == `SEC_OFF_PWR);
   wire hLed   = (cfgWord == `SEC_OFF_LED) & isUp;

   wire sbSsC   = sbLoad.wr & (sbWord == `SEC_OFF_SS_CAP);
   wire sbLtssm = sbLoad.wr & (sbWord == `SEC_OFF_LTSSM);
   wire sbHot   = sbLoad.wr & (sbWord == `SEC_OFF_HOT);
   wire sbPwr   = sbLoad.wr & (sbWord == `SEC_OFF_PWR);

   // Read words
   // R20 downstream header
   wire [31:0] wAcsH = {`SEC_NEXT_SS, `SEC_CAP_VER, `SEC_ID_ACS};
   // R1 R2 fixed capability and size fields
   wire [31:0] wAcs  = {9'h000, acsEn_q, `SEC_EGR_SIZE, 1'b0, `SEC_ACS_CAP_BITS};
   wire [31:0] wEgr  = {24'h000000, egress_q};
   // R5 latency header
   wire [31:0] wLtrH = {`SEC_NEXT_SS, `SEC_CAP_VER, `SEC_ID_LTR};
   wire [31:0] wLat  = {3'h0, noSnoop_q, 3'h0, snoop_q};
   // R8 last header in the chain
   wire [31:0] wSsH  = {`SEC_NEXT_END, `SEC_CAP_VER, `SEC_ID_SS};
   // R9 capability flags at bits 4, 3 and 1
   wire [31:0] wSsC  = {27'h0000000, ssCap_q[2], ssCap_q[1], 1'b0, ssCap_q[0], 1'b0};
   wire [31:0] wSs1  = {28'h0000000, l1En_q[1], 1'b0, l1En_q[0], 1'b0};
   wire [31:0] wLtssm = {24'h000000, ltssm_q};
   wire [31:0] wHot  = {mac_q, hot_q};
   wire [31:0] wSmb  = {1'b0, unsup_q, pecFail_q, 19'h00000, pecDis_q, 1'b0,
                        smbAddr_q, smbSel_q};
   wire [31:0] wFc   = {29'h00000000, fcEn_q, 1'b0};
   wire [31:0] wThr1 = {thrX2_q, thrX1_q};
   wire [31:0] wThr2 = {16'h0000, thrX4_q};
   wire [31:0] wPwr  = {31'h00000000, pwrOff_q};
   wire [31:0] wLed  = {25'h0000000, led_q};

   // R21 reserved bits and unmapped offsets read zero
   wire [31:0] rdMux = ({32{hAcsH}} & wAcsH) | ({32{hAcs}} & wAcs) |
                       ({32{hEgr}} & wEgr) | ({32{hLtrH}} & wLtrH) |
                       ({32{hLat}} & wLat) | ({32{hSsH}} & wSsH) |
                       ({32{hSsC}} & wSsC) | ({32{hSs1}} & wSs1) |
                       ({32{hLtssm}} & wLtssm) | ({32{hHot}} & wHot) |
                       ({32{hSmb}} & wSmb) | ({32{hFc}} & wFc) |
                       ({32{hThr1}} & wThr1) | ({32{hThr2}} & wThr2) |
                       ({32{hPwr}} & wPwr) | ({32{hLed}} & wLed);

   // Byte-enable merge of the addressed word with the write data
   wire [31:0] cfgNew = (rdMux & ~cfgMask) | (cfgReq.data & cfgMask);
   wire [31:0] sbOld  = sbSsC ? wSsC : sbLtssm ? wLtssm : sbHot ? wHot : wPwr;
   wire [31:0] sbNew  = (sbOld & ~sbMask) | (sbLoad.data & sbMask);

   wire wrAcs = cfgReq.wr & hAcs;
   wire wrEgr = cfgReq.wr & hEgr;
   wire wrLat = cfgReq.wr & hLat;
   wire wrSs1 = cfgReq.wr & hSs1;
   wire wrSmb = cfgReq.wr & hSmb;
   wire wrFc  = cfgReq.wr & hFc;
   wire wrT1  = cfgReq.wr & hThr1;
   wire wrT2  = cfgReq.wr & hThr2;
   wire wrPwr = cfgReq.wr & hPwr;
   wire wrLed = cfgReq.wr & hLed;

   // Write-one-clear terms; a same-cycle event still sets the flag
   wire clrPec   = wrSmb & cfgReq.data[`SEC_BIT_PEC_FAIL] & cfgMask[`SEC_BIT_PEC_FAIL];
   wire clrUnsup = wrSmb & cfgReq.data[`SEC_BIT_UNSUP] & cfgMask[`SEC_BIT_UNSUP];
   wire strapTake = ~strapDone_q & (strapCnt_q == `SEC_STRAP_WAIT);

   // R3 access enables
   always_ff @(posedge clock) begin
      if (sys_rst) acsEn_q <= 7'h00;
      else if (wrAcs) acsEn_q <= cfgNew[22:16];
   end

   // R4 egress blocking vector
   always_ff @(posedge clock) begin
      if (sys_rst) egress_q <= 8'h00;
      else if (wrEgr) egress_q <= cfgNew[7:0];
   end

   // R6 R7 both latency halves share one word
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         snoop_q   <= 13'h0000;
         noSnoop_q <= 13'h0000;
      end else if (wrLat) begin
         snoop_q   <= cfgNew[12:0];
         noSnoop_q <= cfgNew[28:16];
      end
   end

   // R11 substate enables
   always_ff @(posedge clock) begin
      if (sys_rst) l1En_q <= 2'h0;
      else if (wrSs1) l1En_q <= {cfgNew[3], cfgNew[1]};
   end

   // R12 R14 sideband select and check disable
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         smbSel_q <= `SEC_SMB_SEL_RST;
         pecDis_q <= `SEC_PEC_DIS_RST;
      end else if (wrSmb) begin
         smbSel_q <= cfgNew[0];
         pecDis_q <= cfgNew[9];
      end
   end

   // R13 address high bits reset, low bits caught from straps after release
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         smbAddr_q   <= {`SEC_SMB_ADDR_HI, 3'h0};
         strapCnt_q  <= 2'h0;
         strapDone_q <= 1'b0;
      end else begin
         if (!strapDone_q) strapCnt_q <= strapCnt_q + 2'h1;
         if (strapTake) strapDone_q <= 1'b1;
         if (strapTake) smbAddr_q <= {smbAddr_q[6:3], strap};
         else if (wrSmb) smbAddr_q <= cfgNew[7:1];
      end
   end

   // R15 R16 sticky event flags
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         pecFail_q <= 1'b0;
         unsup_q   <= 1'b0;
      end else begin
         pecFail_q <= pecFailEv | (pecFail_q & ~clrPec);
         unsup_q   <= unsupCmdEv | (unsup_q & ~clrUnsup);
      end
   end

   // R17 per-port completion flow enables
   always_ff @(posedge clock) begin
      if (sys_rst) fcEn_q <= 2'h0;
      else if (wrFc) fcEn_q <= cfgNew[2:1];
   end

   // R18 thresholds per link width
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         thrX1_q <= `SEC_THR_X1_RST;
         thrX2_q <= `SEC_THR_X2_RST;
      end else if (wrT1) begin
         thrX1_q <= cfgNew[15:0];
         thrX2_q <= cfgNew[31:16];
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) thrX4_q <= `SEC_THR_X4_RST;
      else if (wrT2) thrX4_q <= cfgNew[15:0];
   end

   // R19 sideband load overrides a same-cycle config write
   always_ff @(posedge clock) begin
      if (sys_rst) pwrOff_q <= 1'b0;
      else if (sbPwr) pwrOff_q <= sbNew[0];
      else if (wrPwr) pwrOff_q <= cfgNew[0];
   end

   always_ff @(posedge clock) begin
      if (sys_rst) led_q <= 7'h00;
      else if (wrLed) led_q <= cfgNew[6:0];
   end

   // R10 loadable read-only fields change only from the sideband
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         ssCap_q <= `SEC_SS_CAP_RST;
         ltssm_q <= 8'h00;
         hot_q   <= 16'h0000;
         mac_q   <= `SEC_MAC_RST;
      end else begin
         if (sbSsC) ssCap_q <= {sbNew[4], sbNew[3], sbNew[1]};
         if (sbLtssm) ltssm_q <= sbNew[7:0];
         if (sbHot) begin
            hot_q <= sbNew[15:0];
            mac_q <= sbNew[31:16];
         end
      end
   end

   // Read data is registered: one cycle after the read strobe
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         cfgRdData  <= 32'h00000000;
         cfgRdValid <= 1'b0;
      end else begin
         cfgRdValid <= cfgReq.rd;
         if (cfgReq.rd) cfgRdData <= rdMux;
      end
   end

   assign ctrl.acsEn        = acsEn_q;
   assign ctrl.egressVec    = egress_q;
   assign ctrl.snoopLat     = snoop_q;
   assign ctrl.noSnoopLat   = noSnoop_q;
   assign ctrl.pmL11En      = l1En_q[0];
   assign ctrl.aspmL11En    = l1En_q[1];
   assign ctrl.smbusSel     = smbSel_q;
   assign ctrl.smbusAddr    = smbAddr_q;
   assign ctrl.pecDisable   = pecDis_q;
   assign ctrl.pecFail      = pecFail_q;
   assign ctrl.unsupCmd     = unsup_q;
   assign ctrl.cplFcEn      = fcEn_q;
   assign ctrl.thrX1        = thrX1_q;
   assign ctrl.thrX2        = thrX2_q;
   assign ctrl.thrX4        = thrX4_q;
   assign ctrl.powerSaveOff = pwrOff_q;
   assign ctrl.ledCtl       = led_q;

   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);

   sequence fullWrite;
      cfgReq.wr && (cfgReq.be == 4'hf);
   endsequence

   sequence strapCatch;
      strapTake ##1 1'b1;
   endsequence

   sequence smbRead;
      cfgReq.rd && hSmb;
   endsequence

   acs_cap_read_a: assert property (cfgReq.rd && hAcs |=> // R1
      cfgRdData[15:0] == {`SEC_EGR_SIZE, 1'b0, `SEC_ACS_CAP_BITS})
      else $error("capability or size field wrong");

   acs_en_write_a: assert property (fullWrite and hAcs |=> // R3
      ctrl.acsEn == $past(cfgReq.data[22:16]))
      else $error("access enables not written");

   egress_vec_a: assert property (fullWrite and hEgr |=> // R4
      ctrl.egressVec == $past(cfgReq.data[7:0]))
      else $error("egress vector not written");

   ltr_header_a: assert property (cfgReq.rd && hLtrH |=> // R5
      cfgRdData == {`SEC_NEXT_SS, `SEC_CAP_VER, `SEC_ID_LTR})
      else $error("latency header wrong");

   latency_write_a: assert property (fullWrite and hLat |=> // R6
      ctrl.snoopLat == $past(cfgReq.data[12:0]) &&
      ctrl.noSnoopLat == $past(cfgReq.data[28:16]))
      else $error("latency fields not written");

   ss_header_a: assert property (cfgReq.rd && hSsH |=> // R8
      cfgRdData == {`SEC_NEXT_END, `SEC_CAP_VER, `SEC_ID_SS})
      else $error("substates header wrong");

   ro_loadable_a: assert property (!sbLoad.wr |=> // R10
      $stable(ssCap_q) && $stable(ltssm_q) && $stable(hot_q) && $stable(mac_q))
      else $error("loadable field changed without sideband");

   strap_addr_a: assert property (strapCatch |-> // R13
      smbAddr_q[2:0] == $past(strap) && strapDone_q)
      else $error("strap address not captured");

   pec_sticky_a: assert property (pecFailEv |=> // R15
      ctrl.pecFail ##1 (ctrl.pecFail || $past(clrPec)))
      else $error("check failure flag lost");

   unsup_clear_a: assert property (clrUnsup && !unsupCmdEv |=> // R16
      !ctrl.unsupCmd)
      else $error("unsupported flag not cleared");

   reserved_zero_a: assert property (smbRead |=> // R21
      cfgRdData[28:10] == 19'h00000 && !cfgRdData[31] && !cfgRdData[8])
      else $error("reserved bits not zero");

   pwr_load_a: assert property (sbPwr |=> // R19
      ctrl.powerSaveOff == $past(sbNew[0]))
      else $error("power saving load lost");

endmodule : sec_cfg_regs

//--- verif/sec_sb_model.sv
`timescale 1ns/1ps
module sec_sb_model
   import sec_pkg::*;
(
   input  wire logic clock,
   output sec_req_t  sbLoad,
   output logic      pecFailEv,
   output logic      unsupCmdEv
);

   initial begin
      sbLoad     = '0;
      pecFailEv  = 1'b0;
      unsupCmdEv = 1'b0;
   end

   task automatic load(input logic [11:0] addr, input logic [3:0] be, input logic [31:0] data);
      @(negedge clock);
      sbLoad = '{wr: 1'b1, rd: 1'b0, addr: addr, be: be, data: data};
      @(negedge clock);
      // Released lines show garbage, not the last value
      sbLoad = '{wr: 1'b0, rd: 1'b0, addr: ~addr, be: ~be, data: ~data};
   endtask : load

   task automatic pulse(input logic pec);
      @(negedge clock);
      pecFailEv  = pec;
      unsupCmdEv = ~pec;
      @(negedge clock);
      pecFailEv  = 1'b0;
      unsupCmdEv = 1'b0;
   endtask : pulse

endmodule : sec_sb_model

//--- verif/testbench.sv
`timescale 1ns/1ps
module testbench
   import sec_pkg::*;
;
   logic        clock;
   logic        sys_rst;
   logic        portIsUpPin;
   logic [2:0]  gpioStrapPin;
   sec_req_t    cfgReq;
   sec_req_t    sbLoad;
   logic        pecFailEv;
   logic        unsupCmdEv;
   logic [31:0] cfgRdData;
   logic        cfgRdValid;
   sec_ctrl_t   ctrl;
   int          n_fail;
   int          comparisons;

   sec_cfg_regs sec_cfg_regs_i (.clock(clock), .sys_rst(sys_rst), .portIsUpPin(portIsUpPin),
      .gpioStrapPin(gpioStrapPin), .cfgReq(cfgReq), .sbLoad(sbLoad), .pecFailEv(pecFailEv),
      .unsupCmdEv(unsupCmdEv), .cfgRdData(cfgRdData), .cfgRdValid(cfgRdValid), .ctrl(ctrl));

   sec_sb_model sec_sb_model_i (.clock(clock), .sbLoad(sbLoad), .pecFailEv(pecFailEv),
      .unsupCmdEv(unsupCmdEv));

   initial clock = 1'b0;
   always #25 clock = ~clock;

   task automatic close_out();
      $display("checks %0d, mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : close_out

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic wr(input logic [11:0] addr, input logic [3:0] be, input logic [31:0] data);
      @(negedge clock);
      cfgReq = '{wr: 1'b1, rd: 1'b0, addr: addr, be: be, data: data};
      @(negedge clock);
      cfgReq = '{wr: 1'b0, rd: 1'b0, addr: ~addr, be: ~be, data: ~data};
   endtask : wr

   // Read answer is due one cycle after the request edge
   task automatic rchk(input logic [11:0] addr, input logic [31:0] exp);
      int n;
      @(negedge clock);
      cfgReq = '{wr: 1'b0, rd: 1'b1, addr: addr, be: 4'h0, data: 32'h0};
      for (n = 0; n < 4; n++) begin
         @(negedge clock);
         cfgReq.rd = 1'b0;
         if (cfgRdValid === 1'b1) break;
      end
      if (n != 0) begin
         n_fail++;
         $display("CHECK FAILED t=%0t seen=%h expected=%h", $time, n, 0);
      end
      if (n == 4) close_out();
      else chk(cfgRdData, exp);
   endtask : rchk

   // Straps are only sampled after release, so wait for the syncs
   task automatic do_reset(input logic up, input logic [2:0] strap);
      @(negedge clock);
      sys_rst      = 1'b1;
      portIsUpPin  = up;
      gpioStrapPin = strap;
      repeat (4) @(negedge clock);
      sys_rst = 1'b0;
      repeat (4) @(negedge clock);
   endtask : do_reset

   initial begin
      n_fail       = 0;
      comparisons  = 0;
      cfgReq       = '0;
      sys_rst      = 1'b1;
      portIsUpPin  = 1'b0;
      gpioStrapPin = 3'h5;
      do_reset(1'b0, 3'h5);
      rchk(12'h220, 32'h2401000d);
      rchk(12'h224, 32'h0000087f);
      rchk(12'h228, 32'h00000000);
      rchk(12'h240, 32'h0001001e);
      rchk(12'h244, 32'h00000012);
      rchk(12'h248, 32'h00000000);
      rchk(12'h24c, 32'h00000000);
      rchk(12'h230, 32'h00000000);
      rchk(12'h340, 32'h00040000);
      rchk(12'h360, 32'h00000000);
      wr(12'h224, 4'hf, 32'hffffffff);
      rchk(12'h224, 32'h007f087f);
      chk(32'(ctrl.acsEn), 32'h7f);
      wr(12'h228, 4'h1, 32'h000000a5);
      chk(32'(ctrl.egressVec), 32'ha5);
      wr(12'h228, 4'h0, 32'hffffffff);
      rchk(12'h228, 32'h000000a5);
      wr(12'h228, 4'hf, 32'hffffffff);
      rchk(12'h228, 32'h000000ff);
      wr(12'h248, 4'hf, 32'hffffffff);
      rchk(12'h248, 32'h0000000a);
      chk(32'({ctrl.pmL11En, ctrl.aspmL11En}), 32'h3);
      wr(12'h244, 4'hf, 32'hffffffff);
      rchk(12'h244, 32'h00000012);
      sec_sb_model_i.load(12'h244, 4'hf, 32'hffffffff);
      rchk(12'h244, 32'h0000001a);
      sec_sb_model_i.load(12'h33c, 4'h1, 32'h000000ab);
      rchk(12'h33c, 32'h000000ab);
      sec_sb_model_i.load(12'h340, 4'hf, 32'h12345678);
      rchk(12'h340, 32'h12345678);
      sec_sb_model_i.load(12'h360, 4'h1, 32'h00000001);
      chk(32'(ctrl.powerSaveOff), 32'h1);
      wr(12'h360, 4'hf, 32'h00000000);
      rchk(12'h360, 32'h00000000);
      // Upstream role, second reset in mid-run
      do_reset(1'b1, 3'h3);
      rchk(12'h244, 32'h00000012);
      rchk(12'h230, 32'h24010018);
      rchk(12'h220, 32'h00000000);
      rchk(12'h234, 32'h00000000);
      wr(12'h234, 4'hf, 32'hffffffff);
      rchk(12'h234, 32'h1fff1fff);
      wr(12'h234, 4'h3, 32'h00001c05);
      chk(32'(ctrl.snoopLat), 32'h1c05);
      chk(32'(ctrl.noSnoopLat), 32'h1fff);
      rchk(12'h344, 32'h000002d7);
      chk(32'(ctrl.pecDisable), 32'h1);
      chk(32'(ctrl.smbusAddr), 32'h6b);
      wr(12'h344, 4'h1, 32'h00000000);
      chk(32'(ctrl.smbusSel), 32'h0);
      wr(12'h344, 4'h2, 32'h00000000);
      rchk(12'h344, 32'h00000000);
      chk(32'(ctrl.pecDisable), 32'h0);
      sec_sb_model_i.pulse(1'b1);
      rchk(12'h344, 32'h20000000);
      sec_sb_model_i.pulse(1'b0);
      rchk(12'h344, 32'h60000000);
      wr(12'h344, 4'h8, 32'h20000000);
      rchk(12'h344, 32'h40000000);
      chk(32'({ctrl.pecFail, ctrl.unsupCmd}), 32'h1);
      // Event and clear in one cycle: the event must win
      fork
         wr(12'h344, 4'h8, 32'h40000000);
         sec_sb_model_i.pulse(1'b0);
      join
      rchk(12'h344, 32'h40000000);
      wr(12'h344, 4'h8, 32'h40000000);
      rchk(12'h344, 32'h00000000);
      rchk(12'h350, 32'h00000000);
      wr(12'h350, 4'hf, 32'hffffffff);
      rchk(12'h350, 32'h00000006);
      chk(32'(ctrl.cplFcEn), 32'h3);
      rchk(12'h354, 32'h02000080);
      rchk(12'h358, 32'h00000800);
      wr(12'h354, 4'hf, 32'h12345678);
      chk(32'({ctrl.thrX2, ctrl.thrX1}), 32'h12345678);
      wr(12'h358, 4'hf, 32'hffffffff);
      rchk(12'h358, 32'h0000ffff);
      chk(32'(ctrl.thrX4), 32'hffff);
      rchk(12'h364, 32'h00000000);
      wr(12'h364, 4'hf, 32'hffffffff);
      rchk(12'h364, 32'h0000007f);
      chk(32'(ctrl.ledCtl), 32'h7f);
      rchk(12'h100, 32'h00000000);
      close_out();
   end

endmodule : testbench
